// ---- esv_pkg.sv ----
// Purpose: shared constants of the parallel port fifo service block
// Assumes: 32-bit AXI4-Lite register words, 12-bit byte offsets
// Notes:   field positions, reset values and timing counts live here
package esv_pkg;

  // register byte offsets
  localparam logic [11:0] ADDR_AFIFO = 12'h000;
  localparam logic [11:0] ADDR_DFIFO = 12'h400;
  localparam logic [11:0] ADDR_CTRL  = 12'h408;
  localparam logic [11:0] ADDR_STAT  = 12'h40C;

  // control register fields
  localparam int C_MODE    = 0;
  localparam int C_DIR     = 3;
  localparam int C_DMA_REQUEST_ENABLE   = 4;
  localparam int C_SVCMASK = 5;
  localparam int C_FLTEN_N = 6;
  localparam int C_ACKEN   = 7;
  localparam int C_THR     = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0060;

  // status register fields
  localparam int S_CNT   = 0;
  localparam int S_EMPTY = 5;
  localparam int S_FULL  = 6;
  localparam int S_SVC   = 8;
  localparam int S_TC    = 9;
  localparam int S_FAULT = 10;
  localparam int S_ACK   = 11;

  // port modes
  localparam logic [2:0] MODE_SPP  = 3'h0;
  localparam logic [2:0] MODE_PPF  = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;

  localparam int          FIFO_DEPTH = 16;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  THR_CAP    = 5'h0F;
  localparam logic [5:0]  BURST_MAX  = 6'h20;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic {RLE_IDLE, RLE_EMIT} esv_rle_t;
  typedef enum logic {LQ_IDLE, LQ_SEND}   esv_lq_t;

endpackage

// ---- esv_fifo.sv ----
// Purpose: byte fifo with occupancy count for the port service logic
// Assumes: caller never pushes when full nor pops when empty
// Notes:   flush empties the store in one cycle
`timescale 1ns/1ps
`default_nettype none
module esv_fifo
  import esv_pkg::*;
#(
  parameter int W     = 9,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CW    = CNT_W
) (
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  output logic      [W-1:0]  head,
  output logic      [CW-1:0] count,
  output logic               empty,
  output logic               full
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;

  assign head  = mem[rp];
  assign empty = (count == '0);
  assign full  = (count == FULL_CNT);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= push_data;
    end
  end

  // occupancy 0..16 feeds thresholds and dma decisions
  always_ff @(posedge sys_clk) begin
    if (srst || flush) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wp <= AW'(wp + 1'b1);
      end
      if (pop) begin
        rp <= AW'(rp + 1'b1);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- esv_top.sv ----
// Purpose: fifo service, rle expansion, dma request and irq of the port
// Assumes: sys_clk is also the lpc clock; engine signals share sys_clk
// Notes:   registers on AXI4-Lite; fifo disabled after reset
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module esv_top
  import esv_pkg::*;
#(
  parameter logic [2:0] DMA_CH = 3'h3
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        dma_cycle,
  input  wire logic        dma_tc,
  input  wire logic [7:0]  dma_wdata,
  output logic [7:0]       dma_rdata,
  output logic             ldrq_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_cmd,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_cmd,
  input  wire logic        tx_ready,
  input  wire logic [3:0]  hs_ctrl_n,
  output logic [3:0]       pin_ctrl_n_out,
  output logic [3:0]       pin_ctrl_n_oe,
  input  wire logic        peripheral_fault_n,
  input  wire logic        peripheral_ack_n,
  output logic             irq
);

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  // control state
  logic [2:0] mode;
  logic       dir;
  logic       dma_request_enable;
  logic       service_irq_mask;
  logic       fault_irq_enable_n;
  logic       ack_irq_enable;
  logic [3:0] threshold_field;

  // fifo
  logic       f_push;
  logic [8:0] f_pdata;
  logic       f_pop;
  logic [8:0] f_head;
  logic [4:0] f_cnt;
  logic       f_empty;
  logic       f_full;

  // write channel
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0]  ws;

  // pins, sticky events, rle and request state
  logic       flt_s1, flt_s2, flt_prev;
  logic       ack_s1, ack_s2, ack_prev;
  logic       flt_en_prev;
  logic       tc_pend, fault_pend, ack_pend;
  esv_rle_t   rle_st;
  logic       rle_armed;
  logic [6:0] rle_left;
  logic [7:0] rle_byte;
  esv_lq_t    lq_st;
  logic [3:0] lq_sh;
  logic [1:0] lq_bits;
  logic       lq_act;
  logic       req_sent;
  logic [5:0] burst_cnt;
  logic       burst_hold;

  // mode decode
  wire fifo_on  = (mode == MODE_PPF) || (mode == MODE_ECP) ||
                  (mode == MODE_TEST);
  wire xfer_on  = (mode == MODE_PPF) || (mode == MODE_ECP);
  wire test_on  = (mode == MODE_TEST);
  wire rx_on    = (mode == MODE_ECP) && dir;
  wire host_wr  = fifo_on && (!dir || test_on);
  wire host_rd  = fifo_on && (dir || test_on);

  // thresholds
  wire [4:0] thr_raw = 5'({1'b0, threshold_field} + 5'h01);
  wire [4:0] thr_eff = (thr_raw > THR_CAP) ? THR_CAP : thr_raw;
  wire [4:0] free_space_trigger = 5'(5'h10 - thr_eff);
  wire [4:0] fill_level_trigger = 5'(5'h10 - thr_eff);
  wire [4:0] f_free = 5'(5'h10 - f_cnt);

  // service condition, level while mask and dma_request_enable clear
  wire pio_on   = fifo_on && !service_irq_mask && !dma_request_enable;
  wire wr_cond  = !dir && (f_free >= free_space_trigger);
  wire rd_cond  = dir && (f_cnt >= fill_level_trigger);
  wire svc_lvl  = pio_on && (wr_cond || rd_cond);

  // register write decode
  wire wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wa_ok    = hit(wa, ADDR_AFIFO) || hit(wa, ADDR_DFIFO) ||
                  hit(wa, ADDR_CTRL) || hit(wa, ADDR_STAT);
  wire wr_ctl0  = wr_go && hit(wa, ADDR_CTRL) && ws[0];
  wire wr_ctl1  = wr_go && hit(wa, ADDR_CTRL) && ws[1];
  wire wr_clr   = wr_go && hit(wa, ADDR_STAT) && ws[1];
  wire wr_dport = wr_go && hit(wa, ADDR_DFIFO) && ws[0] && host_wr;
  wire wr_aport = wr_go && hit(wa, ADDR_AFIFO) && ws[0] &&
                  (mode == MODE_ECP) && !dir;

  // register read decode
  wire ar_hs    = s_axi_arvalid && s_axi_arready;
  wire ra_ok    = hit(s_axi_araddr, ADDR_DFIFO) ||
                  hit(s_axi_araddr, ADDR_CTRL) ||
                  hit(s_axi_araddr, ADDR_STAT);
  wire rd_pop   = ar_hs && hit(s_axi_araddr, ADDR_DFIFO) && host_rd &&
                  !f_empty;
  wire [31:0] ctrl_word = {20'h0, threshold_field, ack_irq_enable,
                           fault_irq_enable_n, service_irq_mask,
                           dma_request_enable, dir, mode};
  wire [31:0] stat_word = {20'h0, ack_pend, fault_pend, tc_pend,
                           svc_lvl, 1'b0, f_full, f_empty, f_cnt};
  wire [31:0] rd_word   =
    hit(s_axi_araddr, ADDR_CTRL) ? ctrl_word :
    hit(s_axi_araddr, ADDR_STAT) ? stat_word :
    (hit(s_axi_araddr, ADDR_DFIFO) && host_rd) ? {24'h0, f_head[7:0]} :
    32'h0;

  // dma: one byte per cycle, gated by mask
  wire dma_on   = fifo_on && dma_request_enable && !service_irq_mask;
  wire dma_push = dma_cycle && dma_on && !dir && !f_full;
  wire dma_pop  = dma_cycle && dma_on && dir && !f_empty;
  wire tc_hit   = dma_cycle && dma_tc && dma_request_enable &&
                  !service_irq_mask;
  wire dma_want = dma_on && !burst_hold && !tc_hit &&
                  (dir ? !f_empty : !f_full);

  // reverse byte intake with rle expansion
  wire rx_take  = rx_valid && rx_ready;
  wire rx_count = rx_take && rx_cmd && !rx_data[7];
  wire rx_plain = rx_take && !rx_cmd && !rle_armed;
  wire rle_push = (rle_st == RLE_EMIT) && !f_full;
  wire rle_last = rle_push && (rle_left == 7'h00);

  // forward stage feed
  wire tx_load  = xfer_on && !dir && !f_empty && (!tx_valid || tx_ready);

  // fifo port selection
  assign f_push  = dma_push || wr_dport || wr_aport ||
                   rx_plain || rle_push;
  assign f_pdata = dma_push ? {1'b0, dma_wdata} :
                   wr_aport ? {1'b1, wd[7:0]} :
                   wr_dport ? {1'b0, wd[7:0]} :
                   rle_push ? {1'b0, rle_byte} :
                   {1'b0, rx_data};
  assign f_pop   = dma_pop || rd_pop || tx_load;

  esv_fifo #(
    .W     (9),
    .DEPTH (FIFO_DEPTH),
    .CW    (CNT_W)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .flush     (!fifo_on),
    .push      (f_push),
    .push_data (f_pdata),
    .pop       (f_pop),
    .head      (f_head),
    .count     (f_cnt),
    .empty     (f_empty),
    .full      (f_full)
  );

  // AXI4-Lite write channel
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wa            <= 12'h000;
      wd            <= 32'h0000_0000;
      ws            <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wa            <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd           <= s_axi_wdata;
        ws           <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= ra_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control register; terminal count sets the mask over software
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode               <= MODE_SPP;
      dir                <= CTRL_RST[C_DIR];
      dma_request_enable <= CTRL_RST[C_DMA_REQUEST_ENABLE];
      service_irq_mask   <= CTRL_RST[C_SVCMASK];
      fault_irq_enable_n <= CTRL_RST[C_FLTEN_N];
      ack_irq_enable     <= CTRL_RST[C_ACKEN];
      threshold_field    <= CTRL_RST[C_THR +: 4];
    end else begin
      if (wr_ctl0) begin
        mode               <= wd[C_MODE +: 3];
        dir                <= wd[C_DIR];
        dma_request_enable <= wd[C_DMA_REQUEST_ENABLE];
        service_irq_mask   <= wd[C_SVCMASK];
        fault_irq_enable_n <= wd[C_FLTEN_N];
        ack_irq_enable     <= wd[C_ACKEN];
      end
      if (wr_ctl1) begin
        threshold_field <= wd[C_THR +: 4];
      end
      if (tc_hit) begin
        service_irq_mask <= 1'b1;
      end
    end
  end

  // pin synchronisers and sticky events; set beats clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flt_s1      <= 1'b1;
      flt_s2      <= 1'b1;
      flt_prev    <= 1'b1;
      ack_s1      <= 1'b1;
      ack_s2      <= 1'b1;
      ack_prev    <= 1'b1;
      flt_en_prev <= 1'b1;
      tc_pend     <= 1'b0;
      fault_pend  <= 1'b0;
      ack_pend    <= 1'b0;
      irq         <= 1'b0;
    end else begin
      flt_s1      <= peripheral_fault_n;
      flt_s2      <= flt_s1;
      flt_prev    <= flt_s2;
      ack_s1      <= peripheral_ack_n;
      ack_s2      <= ack_s1;
      ack_prev    <= ack_s2;
      flt_en_prev <= fault_irq_enable_n;
      if (tc_hit) begin
        tc_pend <= 1'b1;
      end else if (wr_clr && wd[S_TC]) begin
        tc_pend <= 1'b0;
      end
      if (!fault_irq_enable_n &&
          ((flt_prev && !flt_s2) || (flt_en_prev && !flt_s2))) begin
        fault_pend <= 1'b1;
      end else if (wr_clr && wd[S_FAULT]) begin
        fault_pend <= 1'b0;
      end
      if (ack_irq_enable && ack_s2 && !ack_prev) begin
        ack_pend <= 1'b1;
      end else if (wr_clr && wd[S_ACK]) begin
        ack_pend <= 1'b0;
      end
      irq <= svc_lvl || tc_pend || fault_pend || ack_pend;
    end
  end

  // run-length expansion of reverse data
  always_ff @(posedge sys_clk) begin
    if (srst || !rx_on) begin
      rle_st    <= RLE_IDLE;
      rle_armed <= 1'b0;
      rle_left  <= 7'h00;
      rle_byte  <= 8'h00;
      rx_ready  <= 1'b0;
    end else begin
      rx_ready <= (rle_st == RLE_IDLE) && !rx_take &&
                  !(rx_take && rle_armed && !rx_cmd) &&
                  (f_cnt < 5'(FIFO_DEPTH - 1));
      unique case (rle_st)
        RLE_IDLE: begin
          if (rx_count) begin
            rle_armed <= 1'b1;
            rle_left  <= rx_data[6:0];
          end else if (rx_take && !rx_cmd && rle_armed) begin
            rle_byte <= rx_data;
            rle_st   <= RLE_EMIT;
            rx_ready <= 1'b0;
          end
        end
        RLE_EMIT: begin
          if (rle_last) begin
            rle_st    <= RLE_IDLE;
            rle_armed <= 1'b0;
          end else if (rle_push) begin
            rle_left <= 7'(rle_left - 7'h01);
          end
        end
      endcase
    end
  end

  // forward output stage toward the handshake engine
  always_ff @(posedge sys_clk) begin
    if (srst || !xfer_on || dir) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_cmd   <= 1'b0;
    end else if (tx_load) begin
      tx_valid <= 1'b1;
      tx_data  <= f_head[7:0];
      tx_cmd   <= f_head[8];
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // dma read data follows the fifo head
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_rdata <= 8'h00;
    end else begin
      dma_rdata <= f_head[7:0];
    end
  end

  // burst limiter: break the request after 32 dma cycles within one request
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      burst_cnt  <= 6'h00;
      burst_hold <= 1'b0;
    end else if (burst_hold) begin
      if (!req_sent && lq_st == LQ_IDLE) begin
        burst_hold <= 1'b0;
        burst_cnt  <= 6'h00;
      end
    end else if (!req_sent) begin
      burst_cnt <= 6'h00;
    end else if (dma_cycle) begin
      burst_cnt <= 6'(burst_cnt + 6'h01);
      if (6'(burst_cnt + 6'h01) == BURST_MAX) begin
        burst_hold <= 1'b1;
      end
    end
  end

  // request encoding: start 0, channel lsb first, active bit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lq_st    <= LQ_IDLE;
      lq_sh    <= 4'h0;
      lq_bits  <= 2'h0;
      lq_act   <= 1'b0;
      req_sent <= 1'b0;
      ldrq_n   <= 1'b1;
    end else begin
      unique case (lq_st)
        LQ_IDLE: begin
          if (dma_want != req_sent) begin
            ldrq_n  <= 1'b0;
            lq_sh   <= {dma_want, DMA_CH};
            lq_act  <= dma_want;
            lq_bits <= 2'h3;
            lq_st   <= LQ_SEND;
          end else begin
            ldrq_n <= 1'b1;
          end
        end
        LQ_SEND: begin
          ldrq_n <= lq_sh[0];
          lq_sh  <= {1'b0, lq_sh[3:1]};
          if (lq_bits == 2'h0) begin
            lq_st    <= LQ_IDLE;
            req_sent <= lq_act;
          end else begin
            lq_bits <= 2'(lq_bits - 2'h1);
          end
        end
      endcase
    end
  end

  // control strobe drivers per mode
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_drv
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          pin_ctrl_n_out[gi] <= 1'b0;
          pin_ctrl_n_oe[gi]  <= 1'b0;
        end else if (mode == MODE_SPP) begin
          pin_ctrl_n_out[gi] <= 1'b0;
          pin_ctrl_n_oe[gi]  <= !hs_ctrl_n[gi];
        end else begin
          pin_ctrl_n_out[gi] <= hs_ctrl_n[gi];
          pin_ctrl_n_oe[gi]  <= 1'b1;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- esv_top_asserts.sv ----
// Purpose: port-level checks of the port service block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every esv_top instance
`timescale 1ns/1ps
`default_nettype none
module esv_top_asserts
  import esv_pkg::*;
#(
  parameter logic [2:0] DMA_CH = 3'h3
) (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        ldrq_n,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [3:0]  pin_ctrl_n_out,
  input wire logic [3:0]  pin_ctrl_n_oe,
  input wire logic        irq
);
  logic [2:0] pos;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // position inside a request frame, 0 while idle
  always_ff @(posedge sys_clk) begin
    if (srst || pos == 3'h4) begin
      pos <= 3'h0;
    end else if (pos != 3'h0 || !ldrq_n) begin
      pos <= pos + 3'h1;
    end
  end

  frame_code_a: assert property (
    pos == 3'h0 && !ldrq_n |=> ldrq_n == DMA_CH[0] ##1
    ldrq_n == DMA_CH[1] ##1 ldrq_n == DMA_CH[2] ##2 ldrq_n)
    else $error("request frame malformed");
  open_drain_a: assert property (
    pin_ctrl_n_oe != 4'hF |-> pin_ctrl_n_out == 4'h0)
    else $error("open-drain pin driven high");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  wr_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rx_pace_a: assert property (
    rx_valid && rx_ready |=> !rx_ready)
    else $error("receive taken twice in a row");
  quiet_start_a: assert property (
    $fell(srst) |-> !irq && ldrq_n)
    else $error("activity right after reset");

  cover property (pos == 3'h4);
  cover property (rx_valid && rx_ready);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind esv_top esv_top_asserts #(.DMA_CH(DMA_CH)) i_esv_top_asserts (.*);
`default_nettype wire

// ---- esv_periph.sv ----
// Purpose: behavioural parallel-port peripheral on the engine streams
// Assumes: bytes offered by the send task, one at a time
// Notes:   sink accepts only every other cycle
`timescale 1ns/1ps
`default_nettype none
module esv_periph (
  input  wire logic       sys_clk,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_cmd,
  output logic            tx_ready
);
  initial begin
    rx_valid = 1'h0;
    rx_data  = 8'h00;
    rx_cmd   = 1'h0;
    tx_ready = 1'h1;
  end

  always @(posedge sys_clk) begin
    tx_ready <= ~tx_ready;
  end

  // commands carry bit 7 as count or channel flag
  task automatic send(input logic c, input logic [7:0] d);
    rx_valid <= 1'h1;
    rx_cmd   <= c;
    rx_data  <= d;
    do @(posedge sys_clk); while (!rx_ready);
    rx_valid <= 1'h0;
    rx_data  <= ~d;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench of the port service block
// Assumes: peripheral model on the engine streams
// Notes:   run ends in print_verdict
`timescale 1ns/1ps
`default_nettype none
module testbench
  import esv_pkg::*;
;
  logic        sys_clk = 1'h0, srst = 1'h1, dma_cycle = 1'h0, dma_tc = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        peripheral_fault_n = 1'h1, peripheral_ack_n = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF, hs_ctrl_n = 4'hA, pin_ctrl_n_out;
  logic [3:0]  pin_ctrl_n_oe;
  logic [7:0]  dma_wdata = 8'h00, dma_rdata, rx_data, tx_data, got;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, ldrq_n, rx_valid, rx_cmd, rx_ready, irq;
  logic        tx_valid, tx_cmd, tx_ready;
  int          fail_count = 0, check_count = 0, cyc = 0, lows = 0;
  logic [17:0] txq = 18'h0;

  always #20 sys_clk = ~sys_clk;
  esv_top i_esv_top (.*);
  esv_periph i_esv_periph (.*);

  always @(posedge sys_clk) begin
    cyc++;
    lows = lows + int'(!ldrq_n);
    if (tx_valid && tx_ready) begin
      txq = {txq[8:0], tx_cmd, tx_data};
    end
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw || w) begin
      @(posedge sys_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    repeat (2) @(posedge sys_clk);
    s_axi_bready <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdr(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge sys_clk);
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic svc(input logic e);
    rdr(ADDR_STAT);
    chk("svc", rd[S_SVC], e);
    chk("irq", irq, e);
  endtask

  task automatic dcyc(input logic t);
    dma_cycle <= 1'h1;
    dma_tc <= t;
    @(posedge sys_clk);
    got = dma_rdata;
    dma_cycle <= 1'h0;
    dma_tc <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rdr(ADDR_CTRL);
    chk("ctrl", rd, CTRL_RST);
    wr(ADDR_DFIFO, 32'h55);
    rdr(ADDR_STAT);
    chk("stat", rd[6:0], 7'h20);
    chk("od oe", pin_ctrl_n_oe, 4'(~hs_ctrl_n));
    rdr(ADDR_AFIFO);
    chk("rd resp", rs, RESP_SLVERR);
    wr(12'h7F0, 32'h0);
    chk("wr resp", rs, RESP_SLVERR);
  endtask

  task automatic t_thresh();
    wr(ADDR_CTRL, 32'h366);
    svc(1'h0);
    wr(ADDR_CTRL, 32'h346);
    svc(1'h1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DFIFO, 32'h10 + i);
    end
    svc(1'h1);
    wr(ADDR_DFIFO, 32'h14);
    svc(1'h0);
    chk("count", rd[4:0], 5'h05);
    wr(ADDR_CTRL, 32'h34E);
    svc(1'h0);
    for (int i = 5; i < 12; i++) begin
      wr(ADDR_DFIFO, 32'h10 + i);
    end
    svc(1'h1);
    for (int i = 0; i < 12; i++) begin
      rdr(ADDR_DFIFO);
      chk("pop", rd[7:0], 8'h10 + i);
    end
    wr(ADDR_CTRL, 32'hF4E);
    svc(1'h0);
    wr(ADDR_CTRL, 32'hF46);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_DFIFO, 32'h20);
    end
    svc(1'h0);
    chk("full", rd[S_FULL], 1'h1);
  endtask

  task automatic t_rle();
    int n;
    n = 0;
    wr(ADDR_CTRL, CTRL_RST);
    wr(ADDR_CTRL, 32'h6B);
    i_esv_periph.send(1'h1, 8'h85);
    i_esv_periph.send(1'h1, 8'h7F);
    i_esv_periph.send(1'h0, 8'h5B);
    chk("pp out", pin_ctrl_n_out, hs_ctrl_n);
    while (n < 128) begin
      rdr(ADDR_STAT);
      if (rd[4:0] != 5'h00) begin
        rdr(ADDR_DFIFO);
        chk("rle", rd[7:0], 8'h5B);
        n++;
      end
    end
    rdr(ADDR_STAT);
    chk("rle end", rd[4:0], 5'h00);
    i_esv_periph.send(1'h0, 8'h33);
    do rdr(ADDR_STAT); while (rd[4:0] == 5'h00);
    chk("single", rd[4:0], 5'h01);
  endtask

  task automatic t_fwd();
    wr(ADDR_CTRL, CTRL_RST);
    wr(ADDR_CTRL, 32'h43);
    wr(ADDR_AFIFO, 32'h05);
    wr(ADDR_DFIFO, 32'h77);
    repeat (6) @(posedge sys_clk);
    chk("tx pair", txq, 18'h20A77);
    svc(1'h1);
  endtask

  task automatic t_evt();
    wr(ADDR_CTRL, CTRL_RST);
    peripheral_fault_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    rdr(ADDR_STAT);
    chk("fault off", rd[S_FAULT], 1'h0);
    wr(ADDR_CTRL, 32'h20);
    rdr(ADDR_STAT);
    chk("fault en", rd[S_FAULT], 1'h1);
    chk("fault irq", irq, 1'h1);
    wr(ADDR_STAT, 32'hC00);
    peripheral_fault_n <= 1'h1;
    peripheral_ack_n <= 1'h0;
    repeat (6) @(posedge sys_clk);
    wr(ADDR_CTRL, 32'hA0);
    peripheral_fault_n <= 1'h0;
    peripheral_ack_n <= 1'h1;
    repeat (6) @(posedge sys_clk);
    rdr(ADDR_STAT);
    chk("fault edge", rd[S_FAULT], 1'h1);
    chk("ack edge", rd[S_ACK], 1'h1);
  endtask

  task automatic t_dma();
    wr(ADDR_CTRL, 32'h6E);
    wr(ADDR_STAT, 32'hE00);
    wr(ADDR_DFIFO, 32'hC1);
    wr(ADDR_DFIFO, 32'hC2);
    lows = 0;
    wr(ADDR_CTRL, 32'h7E);
    chk("masked", lows, 0);
    chk("no irq", irq, 1'h0);
    wr(ADDR_CTRL, 32'h5E);
    do @(posedge sys_clk); while (ldrq_n);
    repeat (6) @(posedge sys_clk);
    dcyc(1'h0);
    chk("dma byte", got, 8'hC1);
    dcyc(1'h1);
    chk("dma tc", got, 8'hC2);
    rdr(ADDR_CTRL);
    chk("tc mask", rd[C_SVCMASK], 1'h1);
    rdr(ADDR_STAT);
    chk("tc flag", rd[S_TC], 1'h1);
    chk("tc irq", irq, 1'h1);
    repeat (8) @(posedge sys_clk);
    lows = 0;
    wr(ADDR_DFIFO, 32'hC3);
    repeat (8) @(posedge sys_clk);
    chk("after tc", lows, 0);
    wr(ADDR_CTRL, 32'h5E);
    do @(posedge sys_clk); while (ldrq_n);
    repeat (6) @(posedge sys_clk);
    dcyc(1'h0);
    chk("resume", got, 8'hC3);
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    t_reset();
    t_thresh();
    t_rle();
    t_fwd();
    t_evt();
    t_dma();
    print_verdict();
  end
endmodule
`default_nettype wire
